// *** src/timer16_pkg.sv ***
package timer16_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PRESCALE_AND_ENABLE = 8'h00;
  localparam logic [7:0] IDX_OUTPUT_AND_WAVEFORM_CONFIG = 8'h01;
  localparam logic [7:0] IDX_STOPPED_OUTPUT_LEVELS = 8'h02;
  localparam logic [7:0] IDX_SPLIT_SELECT = 8'h03;
  localparam logic [7:0] IDX_STATUS_CLEAR_REGISTER = 8'h04;
  localparam logic [7:0] IDX_STATUS_SET_REGISTER = 8'h05;
  localparam logic [7:0] IDX_BUFFER_VALID_CLEAR = 8'h06;
  localparam logic [7:0] IDX_BUFFER_VALID_SET = 8'h07;
  localparam logic [7:0] IDX_COUNT = 8'h20;
  localparam logic [7:0] IDX_PERIOD_VALUE = 8'h26;
  localparam logic [7:0] IDX_COMPARE_VALUE0 = 8'h28;
  localparam logic [7:0] IDX_PERIOD_BUFFER = 8'h36;
  localparam logic [7:0] IDX_COMPARE_BUFFER0 = 8'h38;
  // Compare registers sit two indices apart
  localparam logic [7:0] IDX_CHANNEL_STRIDE = 8'h02;

  // Field positions
  localparam int ENABLE_BIT = 0;
  localparam int PRESCALE_LSB = 1;
  localparam int WAVEFORM_LSB = 0;
  localparam int AUTO_LOCK_BIT = 3;
  localparam int OVERRIDE_LSB = 4;
  localparam int SPLIT_BIT = 0;
  localparam int DIR_BIT = 0;
  localparam int UPDATE_LOCK_BIT = 1;
  localparam int COMMAND_LSB = 2;
  localparam int PERIOD_VALID_BIT = 0;
  localparam int COMPARE_VALID_LSB = 1;

  // Values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_PERIOD = 16'hFFFF;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Prescaler counter width covers the largest divisor of 1024
  localparam int PRESCALE_W = 10;

  typedef enum logic [2:0] {
    NORMAL_MODE = 3'h0,
    FREQUENCY_WAVE = 3'h1,
    SINGLE_RAMP_PWM = 3'h3,
    DUAL_RAMP_FLAG_TOP = 3'h5,
    DUAL_RAMP_FLAG_BOTH = 3'h6,
    DUAL_RAMP_FLAG_BOTTOM = 3'h7
  } waveform_mode_t;

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_UPDATE = 2'h1,
    CMD_RESTART = 2'h2,
    CMD_HARD_RESET = 2'h3
  } command_t;
endpackage

// *** src/timer16_control.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Prescale select divides clock by 1..1024
// - Counter runs only while enable is set
// - Override enable lets waveform replace port value outside normal mode
// - Auto-lock holds lock until enabled buffers valid
// - Enabling auto-lock sets lock at once
// - Without auto-lock, only software changes lock
// - Normal mode: period top, update/flag at top counting up, at bottom counting down
// - Three-bit waveform mode field; 010, 100 reserved
// - Frequency mode: compare 0 is top
// - PWM modes pick update and overflow points
// - Waveform reaches pin only when override enabled
// - Stopped timer: output-level writes set waveform outputs
// - Split bit makes two independent 8-bit counters
// - Clear register: ones clear, zeros keep
// - Set and clear registers read same status
// - Command reads zero; update, restart, hard reset
// - Lock blocks buffer copy on update
// - Buffer valid set on write, cleared on update
// - Direction bit: 0 up, 1 down, software writable
module timer16_control
  import timer16_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pins, same clock domain as the port logic
  input wire logic [2:0] port_value,
  output logic [2:0] pin_out,
  // Timer state
  output logic [2:0] waveform_output,
  output logic overflow_flag,
  output logic update_event,
  output logic [15:0] count_value
);
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_c_q;
  logic [7:0] ctrl_d_q;
  logic dir_q;
  logic update_lock_q;
  logic [3:0] buf_valid_q;
  logic [15:0] cnt_q;
  logic [15:0] period_q;
  logic [15:0] period_buf_q;
  logic [15:0] cmp_q [3];
  logic [15:0] cmp_buf_q [3];
  logic [2:0] wave_q;
  logic [2:0] pin_q;
  logic ovf_q;
  logic upd_q;
  logic [PRESCALE_W-1:0] pre_q;

  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Divisor minus one for each prescale select code
  function automatic logic [PRESCALE_W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h0: div_mask = 10'h000;
      3'h1: div_mask = 10'h001;
      3'h2: div_mask = 10'h003;
      3'h3: div_mask = 10'h007;
      3'h4: div_mask = 10'h00F;
      3'h5: div_mask = 10'h03F;
      3'h6: div_mask = 10'h0FF;
      default: div_mask = 10'h3FF;
    endcase
  endfunction

  // Merge byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Register index of a byte address; the two low address bits and bits above 9 are ignored
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i <= IDX_BUFFER_VALID_SET) || (i == IDX_COUNT) ||
                (i == IDX_PERIOD_VALUE) || (i == IDX_PERIOD_BUFFER) ||
                (i == IDX_COMPARE_VALUE0) || (i == IDX_COMPARE_VALUE0 + IDX_CHANNEL_STRIDE) ||
                (i == IDX_COMPARE_VALUE0 + 8'h04) || (i == IDX_COMPARE_BUFFER0) ||
                (i == IDX_COMPARE_BUFFER0 + IDX_CHANNEL_STRIDE) ||
                (i == IDX_COMPARE_BUFFER0 + 8'h04);
  endfunction

  // Decoded configuration
  logic enabled;
  logic auto_lock;
  logic split_on;
  logic [2:0] override_en;
  logic [2:0] wmode;
  logic dual;
  logic [15:0] top;
  assign enabled = ctrl_a_q[ENABLE_BIT];
  assign auto_lock = ctrl_b_q[AUTO_LOCK_BIT];
  assign override_en = ctrl_b_q[OVERRIDE_LSB +: 3];
  assign wmode = ctrl_b_q[WAVEFORM_LSB +: 3];
  assign split_on = ctrl_d_q[SPLIT_BIT];
  assign dual = wmode[2];
  assign top = (wmode == FREQUENCY_WAVE) ? cmp_q[0] : period_q;

  // Bus write strobe and decode
  logic wr_go;
  logic [7:0] widx;
  logic [1:0] cmd;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign widx = reg_index(awaddr_q);
  assign cmd = wdata_q[COMMAND_LSB +: 2];

  logic wr_a;
  logic wr_c;
  logic wr_eclr;
  logic wr_eset;
  logic wr_per_buf;
  logic [2:0] wr_cmp_buf;
  assign wr_a = wr_go && wstrb_q[0] && widx == IDX_PRESCALE_AND_ENABLE;
  assign wr_c = wr_go && wstrb_q[0] && widx == IDX_STOPPED_OUTPUT_LEVELS;
  assign wr_eclr = wr_go && wstrb_q[0] && widx == IDX_STATUS_CLEAR_REGISTER;
  assign wr_eset = wr_go && wstrb_q[0] && widx == IDX_STATUS_SET_REGISTER;
  assign wr_per_buf = wr_go && widx == IDX_PERIOD_BUFFER;
  always_comb
  begin
    for (int n = 0; n < 3; n++)
    begin
      wr_cmp_buf[n] = wr_go && widx == IDX_COMPARE_BUFFER0 + IDX_CHANNEL_STRIDE * n[7:0];
    end
  end

  // Commands; hard reset only while stopped
  logic cmd_update;
  logic cmd_restart;
  logic cmd_hard;
  assign cmd_update = wr_eset && cmd == CMD_UPDATE;
  assign cmd_restart = wr_eset && cmd == CMD_RESTART;
  assign cmd_hard = wr_eset && cmd == CMD_HARD_RESET && !enabled;

  // Prescaled tick
  logic tick;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enabled || cmd_restart)
      pre_q <= '0;
    else
      pre_q <= pre_q + 10'h001;
  end
  assign tick = enabled && ((pre_q & div_mask(ctrl_a_q[PRESCALE_LSB +: 3])) ==
                div_mask(ctrl_a_q[PRESCALE_LSB +: 3]));

  // Count events per waveform mode
  logic at_top;
  logic at_bottom;
  logic wrap;
  logic upd_cond;
  logic ovf_cond;
  assign at_top = tick && !split_on && !dir_q && cnt_q == top;
  assign at_bottom = tick && !split_on && dir_q && cnt_q == 16'h0000;
  assign wrap = at_top || at_bottom;
  always_comb
  begin
    case (wmode)
      NORMAL_MODE, FREQUENCY_WAVE:
      begin
        upd_cond = wrap;
        ovf_cond = wrap;
      end
      SINGLE_RAMP_PWM:
      begin
        upd_cond = wrap;
        ovf_cond = wrap;
      end
      DUAL_RAMP_FLAG_TOP:
      begin
        upd_cond = at_bottom;
        ovf_cond = at_top;
      end
      DUAL_RAMP_FLAG_BOTH:
      begin
        upd_cond = at_bottom;
        ovf_cond = at_top || at_bottom;
      end
      DUAL_RAMP_FLAG_BOTTOM:
      begin
        upd_cond = at_bottom;
        ovf_cond = at_bottom;
      end
      default:
      begin
        // Reserved codes do not count events
        upd_cond = 1'b0;
        ovf_cond = 1'b0;
      end
    endcase
  end

  logic upd_any;
  logic do_copy;
  logic all_valid;
  assign upd_any = upd_cond || cmd_update;
  assign do_copy = upd_any && !update_lock_q;
  assign all_valid = &(buf_valid_q[COMPARE_VALID_LSB +: 3] | ~override_en);

  // Control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_hard)
    begin
      ctrl_a_q <= RESET_BYTE;
      ctrl_b_q <= RESET_BYTE;
      ctrl_c_q <= RESET_BYTE;
      ctrl_d_q <= RESET_BYTE;
    end
    else if (wr_go && wstrb_q[0])
    begin
      if (widx == IDX_PRESCALE_AND_ENABLE)
        ctrl_a_q <= {4'h0, wdata_q[3:0]};
      else if (widx == IDX_OUTPUT_AND_WAVEFORM_CONFIG)
        ctrl_b_q <= {1'b0, wdata_q[6:0]};
      else if (widx == IDX_STOPPED_OUTPUT_LEVELS)
        ctrl_c_q <= {5'h00, wdata_q[2:0]};
      else if (widx == IDX_SPLIT_SELECT)
        ctrl_d_q <= {7'h00, wdata_q[0]};
    end
  end

  // Update lock: set wins over clear where both arrive together
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_hard)
      update_lock_q <= 1'b0;
    else if (wr_eset && wdata_q[UPDATE_LOCK_BIT])
      update_lock_q <= 1'b1;
    else if (auto_lock && upd_any)
      update_lock_q <= 1'b1;
    else if (auto_lock && update_lock_q && all_valid)
      update_lock_q <= 1'b0;
    else if (wr_eclr && wdata_q[UPDATE_LOCK_BIT])
      update_lock_q <= 1'b0;
    else if (wr_go && wstrb_q[0] && widx == IDX_OUTPUT_AND_WAVEFORM_CONFIG &&
             wdata_q[AUTO_LOCK_BIT] && !auto_lock)
      update_lock_q <= 1'b1;
  end

  // Buffer valid flags; a buffer write wins over the update clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_hard)
      buf_valid_q <= 4'h0;
    else
    begin
      for (int n = 0; n < 4; n++)
      begin
        if ((n == 0) ? wr_per_buf : wr_cmp_buf[n-1])
          buf_valid_q[n] <= 1'b1;
        else if (wr_go && wstrb_q[0] && widx == IDX_BUFFER_VALID_SET && wdata_q[n])
          buf_valid_q[n] <= 1'b1;
        else if (do_copy)
          buf_valid_q[n] <= 1'b0;
        else if (wr_go && wstrb_q[0] && widx == IDX_BUFFER_VALID_CLEAR && wdata_q[n])
          buf_valid_q[n] <= 1'b0;
      end
    end
  end

  // Buffers and active values; only valid buffers are copied
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_hard)
    begin
      period_q <= RESET_PERIOD;
      period_buf_q <= RESET_PERIOD;
      for (int n = 0; n < 3; n++)
      begin
        cmp_q[n] <= RESET_WORD;
        cmp_buf_q[n] <= RESET_WORD;
      end
    end
    else
    begin
      if (wr_go && widx == IDX_PERIOD_VALUE)
        period_q <= merge16(period_q, wdata_q, wstrb_q);
      else if (do_copy && buf_valid_q[PERIOD_VALID_BIT])
        period_q <= period_buf_q;
      if (wr_per_buf)
        period_buf_q <= merge16(period_buf_q, wdata_q, wstrb_q);
      for (int n = 0; n < 3; n++)
      begin
        if (wr_go && widx == IDX_COMPARE_VALUE0 + IDX_CHANNEL_STRIDE * n[7:0])
          cmp_q[n] <= merge16(cmp_q[n], wdata_q, wstrb_q);
        else if (do_copy && buf_valid_q[COMPARE_VALID_LSB + n])
          cmp_q[n] <= cmp_buf_q[n];
        if (wr_cmp_buf[n])
          cmp_buf_q[n] <= merge16(cmp_buf_q[n], wdata_q, wstrb_q);
      end
    end
  end

  // Counter; in split mode each byte is its own down counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_hard || cmd_restart)
      cnt_q <= RESET_WORD;
    else if (wr_go && widx == IDX_COUNT)
      cnt_q <= merge16(cnt_q, wdata_q, wstrb_q);
    else if (tick && split_on)
    begin
      cnt_q[7:0] <= (cnt_q[7:0] == 8'h00) ? period_q[7:0] : cnt_q[7:0] - 8'h01;
      cnt_q[15:8] <= (cnt_q[15:8] == 8'h00) ? period_q[15:8] : cnt_q[15:8] - 8'h01;
    end
    else if (tick)
    begin
      if (dual && wrap)
        cnt_q <= dir_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      else if (wrap)
        cnt_q <= dir_q ? top : RESET_WORD;
      else
        cnt_q <= dir_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    end
  end

  // Direction: dual-slope turns at top and bottom, software may also write it
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_hard || cmd_restart)
      dir_q <= 1'b0;
    else if (wr_eset && wdata_q[DIR_BIT])
      dir_q <= 1'b1;
    else if (wr_eclr && wdata_q[DIR_BIT])
      dir_q <= 1'b0;
    else if (dual && at_top)
      dir_q <= 1'b1;
    else if (dual && at_bottom)
      dir_q <= 1'b0;
  end

  // Waveform generator outputs
  logic [2:0] match;
  always_comb
  begin
    for (int n = 0; n < 3; n++)
    begin
      match[n] = tick && !split_on && cnt_q == cmp_q[n];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_hard || cmd_restart)
      wave_q <= 3'h0;
    else if (!enabled)
    begin
      if (wr_c)
        wave_q <= wdata_q[2:0];
    end
    else
    begin
      case (wmode)
        FREQUENCY_WAVE:
          wave_q[0] <= wave_q[0] ^ match[0];
        SINGLE_RAMP_PWM:
        begin
          for (int n = 0; n < 3; n++)
          begin
            if (wrap)
              wave_q[n] <= 1'b1;
            else if (match[n])
              wave_q[n] <= 1'b0;
          end
        end
        DUAL_RAMP_FLAG_TOP, DUAL_RAMP_FLAG_BOTH, DUAL_RAMP_FLAG_BOTTOM:
        begin
          // High while the count is below the compare value
          for (int n = 0; n < 3; n++)
          begin
            if (match[n])
              wave_q[n] <= dir_q;
          end
        end
        default:
          wave_q <= wave_q;
      endcase
    end
  end

  // Pin override; the port register still sets pin direction outside this block
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_q <= 3'h0;
    else
    begin
      for (int n = 0; n < 3; n++)
      begin
        pin_q[n] <= (override_en[n] && wmode != NORMAL_MODE) ? wave_q[n] :
                    port_value[n];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovf_q <= 1'b0;
      upd_q <= 1'b0;
    end
    else
    begin
      ovf_q <= ovf_cond;
      upd_q <= do_copy;
    end
  end

  // AXI write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // AXI read channel: one-cycle answer, status read from either register
  logic [7:0] ridx;
  logic [31:0] rword;
  assign ridx = reg_index(s_axi_araddr);
  always_comb
  begin
    rword = 32'h0000_0000;
    if (ridx == IDX_PRESCALE_AND_ENABLE)
      rword[7:0] = ctrl_a_q;
    else if (ridx == IDX_OUTPUT_AND_WAVEFORM_CONFIG)
      rword[7:0] = ctrl_b_q;
    else if (ridx == IDX_STOPPED_OUTPUT_LEVELS)
      rword[7:0] = ctrl_c_q;
    else if (ridx == IDX_SPLIT_SELECT)
      rword[7:0] = ctrl_d_q;
    else if (ridx == IDX_STATUS_CLEAR_REGISTER || ridx == IDX_STATUS_SET_REGISTER)
      rword[7:0] = {6'h00, update_lock_q, dir_q};
    else if (ridx == IDX_BUFFER_VALID_CLEAR || ridx == IDX_BUFFER_VALID_SET)
      rword[7:0] = {4'h0, buf_valid_q};
    else if (ridx == IDX_COUNT)
      rword[15:0] = cnt_q;
    else if (ridx == IDX_PERIOD_VALUE)
      rword[15:0] = period_q;
    else if (ridx == IDX_PERIOD_BUFFER)
      rword[15:0] = period_buf_q;
    else
    begin
      for (int n = 0; n < 3; n++)
      begin
        if (ridx == IDX_COMPARE_VALUE0 + IDX_CHANNEL_STRIDE * n[7:0])
          rword[15:0] = cmp_q[n];
        if (ridx == IDX_COMPARE_BUFFER0 + IDX_CHANNEL_STRIDE * n[7:0])
          rword[15:0] = cmp_buf_q[n];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rword;
      rresp_q <= is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pin_out = pin_q;
  assign waveform_output = wave_q;
  assign overflow_flag = ovf_q;
  assign update_event = upd_q;
  assign count_value = cnt_q;
endmodule

// *** sim/timer16_control_sva.sv ***
`timescale 1ns/1ps
module timer16_control_sva
  import timer16_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Pins
  input wire logic [2:0] port_value,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] waveform_output
);
  logic [7:0] rd_idx_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Index of the read in flight, so its data can be judged
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_idx_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_idx_q <= s_axi_araddr[9:2];
  end

  // Reset itself is the cause here, so the default disable is lifted
  a_ready_reset: assert property (disable iff (1'b0)
    !aresetn |=> s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid)
    else $error("bus not idle after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  a_pin_source: assert property ($past(aresetn) |->
    ((pin_out ^ $past(port_value)) & (pin_out ^ $past(waveform_output))) == 3'h0)
    else $error("pin driven from neither port nor waveform");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_cmd_reads_zero: assert property (s_axi_rvalid &&
    (rd_idx_q == IDX_STATUS_CLEAR_REGISTER || rd_idx_q == IDX_STATUS_SET_REGISTER) |->
    s_axi_rdata[31:2] == 30'h0)
    else $error("command field read nonzero");
endmodule

bind timer16_control timer16_control_sva #(.ADDR_W(ADDR_W)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .port_value(port_value), .pin_out(pin_out),
  .waveform_output(waveform_output)
);

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module testbench;
  import timer16_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, upd_seen;
  logic awready, wready, bvalid, arready, rvalid, overflow_flag, update_event;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] port_value, pin_out, waveform_output;
  logic [15:0] count_value, c;
  int failures, checked, ovf_n, tol;
  int ovf_exp[8] = '{15, 30, 0, 15, 0, 10, 20, 10};
  int divs[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

  timer16_control u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_value(port_value), .pin_out(pin_out), .waveform_output(waveform_output),
    .overflow_flag(overflow_flag), .update_event(update_event), .count_value(count_value)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Falling edge, so the counts never race the stimulus
  always @(negedge aclk)
  begin
    if (overflow_flag === 1'b1) ovf_n++;
    if (update_event === 1'b1) upd_seen = 1'b1;
  end

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    awaddr <= {2'b00, idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    `CHK(bresp, er)
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    `CHK(rdata, e)
    `CHK(rresp, er)
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic t_reset_values();
    for (int i = 0; i < 8; i++)
      rd(8'(i), 32'h0);
    rd(IDX_PERIOD_VALUE, 32'hFFFF);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'hFF, RESP_SLVERR);
  endtask

  task automatic t_levels();
    wr(IDX_STOPPED_OUTPUT_LEVELS, 32'h5);
    repeat (2) @(posedge aclk);
    `CHK(waveform_output, 3'b101)
    wr(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'h70);
    repeat (2) @(posedge aclk);
    `CHK(pin_out, 3'b010)
    wr(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'h71);
    repeat (2) @(posedge aclk);
    `CHK(pin_out, 3'b101)
    wr(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'h31);
    repeat (2) @(posedge aclk);
    `CHK(pin_out, 3'b001)
  endtask

  // Top of 3 and compare 0 of 1 set each mode's expected overflow count; reserved codes give none
  task automatic t_modes();
    wr(IDX_PERIOD_VALUE, 32'h3);
    wr(IDX_COMPARE_VALUE0, 32'h1);
    for (int m = 0; m < 8; m++)
    begin
      wr(IDX_STATUS_SET_REGISTER, 32'h8);
      wr(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'(m));
      rd(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'(m));
      ovf_n = 0;
      wr(IDX_PRESCALE_AND_ENABLE, 32'h1);
      repeat (60) @(posedge aclk);
      wr(IDX_PRESCALE_AND_ENABLE, 32'h0);
      tol = (ovf_exp[m] + 7) / 8;
      `CHK(ovf_n inside {[ovf_exp[m] - tol : ovf_exp[m] + tol]}, 1'b1)
    end
  endtask

  task automatic t_prescale();
    wr(IDX_PERIOD_VALUE, 32'hFFFF);
    wr(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'h0);
    for (int s = 0; s < 8; s++)
    begin
      wr(IDX_STATUS_SET_REGISTER, 32'h8);
      wr(IDX_PRESCALE_AND_ENABLE, 32'(s * 2 + 1));
      repeat (4096) @(posedge aclk);
      wr(IDX_PRESCALE_AND_ENABLE, 32'(s * 2));
      c = count_value;
      `CHK(int'(c) inside {[4096 / divs[s] : 4096 / divs[s] + 8]}, 1'b1)
      repeat (20) @(posedge aclk);
      `CHK(count_value, c)
    end
  endtask

  task automatic t_lock();
    wr(IDX_STATUS_SET_REGISTER, 32'h2);
    rd(IDX_STATUS_CLEAR_REGISTER, 32'h2);
    wr(IDX_STATUS_SET_REGISTER, 32'h1);
    wr(IDX_STATUS_CLEAR_REGISTER, 32'h1);
    rd(IDX_STATUS_SET_REGISTER, 32'h2);
    wr(IDX_COMPARE_BUFFER0, 32'h1234);
    wr(IDX_PERIOD_BUFFER, 32'h55);
    rd(IDX_BUFFER_VALID_SET, 32'h3);
    upd_seen = 1'b0;
    wr(IDX_STATUS_SET_REGISTER, 32'h4);
    rd(IDX_COMPARE_VALUE0, 32'h1);
    rd(IDX_STATUS_CLEAR_REGISTER, 32'h2);
    `CHK(upd_seen, 1'b0)
    wr(IDX_STATUS_CLEAR_REGISTER, 32'h2);
    wr(IDX_STATUS_SET_REGISTER, 32'h4);
    rd(IDX_COMPARE_VALUE0, 32'h1234);
    rd(IDX_PERIOD_VALUE, 32'h55);
    rd(IDX_BUFFER_VALID_CLEAR, 32'h0);
    `CHK(upd_seen, 1'b1)
    wr(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'h38);
    rd(IDX_STATUS_SET_REGISTER, 32'h2);
    wr(IDX_COMPARE_BUFFER0, 32'h11);
    rd(IDX_STATUS_SET_REGISTER, 32'h2);
    wr(IDX_COMPARE_BUFFER0 + IDX_CHANNEL_STRIDE, 32'h22);
    rd(IDX_STATUS_SET_REGISTER, 32'h0);
    wr(IDX_STATUS_SET_REGISTER, 32'h4);
    rd(IDX_STATUS_SET_REGISTER, 32'h2);
    rd(IDX_COMPARE_VALUE0 + IDX_CHANNEL_STRIDE, 32'h22);
    wr(IDX_BUFFER_VALID_SET, 32'h9);
    wr(IDX_BUFFER_VALID_CLEAR, 32'h1);
    rd(IDX_BUFFER_VALID_CLEAR, 32'h8);
  endtask

  task automatic t_hard_reset();
    wr(IDX_PRESCALE_AND_ENABLE, 32'h1);
    wr(IDX_STATUS_SET_REGISTER, 32'hC);
    rd(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'h38);
    wr(IDX_PRESCALE_AND_ENABLE, 32'h0);
    wr(IDX_STATUS_SET_REGISTER, 32'hC);
    rd(IDX_OUTPUT_AND_WAVEFORM_CONFIG, 32'h0);
    rd(IDX_PERIOD_VALUE, 32'hFFFF);
  endtask

  task automatic t_split();
    wr(IDX_PERIOD_VALUE, 32'h3);
    wr(IDX_SPLIT_SELECT, 32'h1);
    rd(IDX_SPLIT_SELECT, 32'h1);
    ovf_n = 0;
    wr(IDX_PRESCALE_AND_ENABLE, 32'h1);
    repeat (40) @(posedge aclk);
    `CHK(ovf_n, 0)
    c = count_value;
    repeat (3) @(posedge aclk);
    `CHK(count_value !== c, 1'b1)
  endtask

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge aclk);
    failures++;
    print_verdict();
  end

  initial
  begin
    failures = 0;
    checked = 0;
    ovf_n = 0;
    upd_seen = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    port_value = 3'b010;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_levels();
    t_modes();
    t_prescale();
    t_lock();
    t_hard_reset();
    t_split();
    print_verdict();
  end
endmodule
